// file: include/istr_pkg.sv
/*
 * constants, carriers and helpers of the init sync and timing refinement block.
 * assumes a single 50 MHz clock and a 32-bit classic wishbone register bus.
 */
package istr_pkg;

   localparam int CLK_MHZ = 50;
   localparam int WB_AW   = 5;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [4:0] OFF_CTRL     = 5'h00;
   localparam logic [4:0] OFF_NODE_ID  = 5'h04;
   localparam logic [4:0] OFF_CMD      = 5'h08;
   localparam logic [4:0] OFF_SUCC_ID  = 5'h0c;
   localparam logic [4:0] OFF_STATUS   = 5'h10;
   localparam logic [4:0] OFF_INT_STAT = 5'h14;
   localparam logic [4:0] OFF_INT_MASK = 5'h18;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] NODE_RST = 8'h00;

   // commands
   localparam logic [7:0] CMD_CLR_TXRX_INT = 8'h1e;
   localparam logic [7:0] CMD_CLR_FLAG     = 8'h08;
   localparam logic [7:0] CMD_EN_TX        = 8'h03;
   localparam logic [7:0] CMD_EN_RX        = 8'h04;

   // start-up ram pattern
   localparam logic [7:0]  INIT_PATTERN = 8'hd1;
   localparam logic [10:0] INIT_ADDR0   = 11'h000;
   localparam logic [10:0] INIT_ADDR1   = 11'h001;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int INIT_LIMIT_NS  = 6000;
   localparam int INIT_LIMIT_CYC = INIT_LIMIT_NS * CLK_MHZ / 1000;
   localparam int INTDIS_MIN_NS  = 200;
   localparam int INTDIS_REF_CYC = (INTDIS_MIN_NS * CLK_MHZ + 999) / 1000 + 1;
   localparam int CMD_GAP_NS     = 100;
   localparam int CMD_GAP_REF_CYC = (CMD_GAP_NS * CLK_MHZ + 999) / 1000;
   // legacy figures in rate-clock ticks, rate clock is eight times data rate
   localparam int INTDIS_LEGACY_TICKS  = 4;
   localparam int CMD_GAP_LEGACY_TICKS = 2;

   // interrupt event bits
   localparam int EV_INIT = 0;
   localparam int EV_TA   = 1;
   localparam int EV_RI   = 2;
   localparam int EV_W    = 3;

   // status register bits
   localparam int ST_TA   = 0;
   localparam int ST_RI   = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_RATE = 4;

   typedef struct packed {
      logic [2:0] rate_prescale_select;
      logic       multiplier_select_hi;
      logic       multiplier_select_lo;
      logic       arb_clock_halving;
      logic       refinement_enable;
      logic       idle_wait_bypass;
   } istr_ctrl_s;

   typedef struct packed {
      logic        we;
      logic [10:0] addr;
      logic [7:0]  data;
   } istr_ram_wr_s;

   typedef enum logic [2:0] {
      UPC_IDLE   = 3'b000,
      UPC_SYNC   = 3'b001,
      UPC_WR_PAT = 3'b010,
      UPC_WR_ID  = 3'b011
   } istr_upc_e;

   // true while the micro-program sits in the initialization routine
   function automatic logic in_init_routine(input istr_upc_e pc);
      in_init_routine = (pc == UPC_SYNC) || (pc == UPC_WR_PAT) || (pc == UPC_WR_ID);
   endfunction : in_init_routine

endpackage : istr_pkg

// file: design/istr_rate_div.sv
/*
 * enable-pulse divider: one tick_o every div_i enabled cycles.
 * assumes en_i and div_i come from logic on clk_i; div_i of zero acts as one.
 */
`timescale 1ns/10ps
module istr_rate_div #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         en_i,
   input  wire logic [W-1:0] div_i,
   output logic              tick_o
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         wrap;

   always_comb begin
      wrap   = (cnt_q + W'(1) >= div_i);
      tick_o = en_i && wrap;
      cnt_d  = cnt_q;
      if (en_i) begin
         cnt_d = wrap ? '0 : cnt_q + W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule : istr_rate_div

// file: design/istr_top.sv
/*
 * start-up ram init gating, interrupt disable timing, prescaler select sync,
 * command write spacing and tx/rx flag timing, behind a classic wishbone slave.
 * assumes clk_i at 50 MHz, synchronous reset, line_idle_i from a pin.
 */
// Functional notes
// - arb period is op period, doubled when halving
// - init writes wait for idle line unless bypassed
// - node write stores d1 at 000, id at 001
// - bypass suppresses idle wait inside init routine
// - refinement enable off keeps legacy timing
// - clear commands or successor read deassert interrupt briefly
// - disable time rate-scaled, or over 200 ns refined
// - refined: rate select synchronized into prescaler
// - legacy command write spacing scales with rate
// - refined command spacing fixed 100 ns
// - refined flags rise at setting pulse end
`timescale 1ns/10ps
module istr_top (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [istr_pkg::WB_AW-1:0] wb_adr_i,
   input  wire logic [31:0]               wb_dat_i,
   input  wire logic [3:0]                wb_sel_i,
   output logic [31:0]                    wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic                      line_idle_i,
   input  wire logic [7:0]                successor_identifier_i,
   input  wire logic                      ta_set_pulse_i,
   input  wire logic                      ri_set_pulse_i,
   output logic                           transmitter_available_flag_o,
   output logic                           receiver_inhibited_flag_o,
   output istr_pkg::istr_ram_wr_s         ram_wr_o,
   output logic                           arb_tick_o,
   output logic                           rate_tick_o,
   output logic [2:0]                     rate_prescale_select_o,
   output logic                           interrupt_out_n_o
);

   localparam int INIT_BOUND = 300;

   istr_pkg::istr_ctrl_s    ctrl_q, ctrl_d;
   logic [7:0]              node_q, node_d;
   logic [7:0]              mask_q, mask_d;
   logic [istr_pkg::EV_W-1:0] ev_q, ev_d;
   logic                    ack_q, ack_d;
   logic [31:0]             dat_q, dat_d;
   logic                    idle_s1_q, idle_s2_q;
   istr_pkg::istr_upc_e     upc_q, upc_d;
   istr_pkg::istr_ram_wr_s  ram_q, ram_d;
   logic [2:0]              rsync1_q, rsync1_d, rsync2_q, rsync2_d;
   logic [7:0]              dis_q, dis_d;
   logic [7:0]              gap_q, gap_d;
   logic [1:0]              flag_q, flag_d;
   logic [1:0]              pulse_q;
   logic                    int_n_q, int_n_d;
   logic                    req, stall, wr_acc, rd_acc, node_wr, cmd_wr, clear_trig;
   logic [2:0]              rate_eff;
   logic [1:0]              pulses;
   logic [istr_pkg::EV_W-1:0] ev_set;
   logic [7:0]              op_div, arb_div, rate_div;
   logic                    op_tick;

   ////////////////////////////////////////////////////////////////////////////
   // clock enables
   always_comb begin
      unique case ({ctrl_q.multiplier_select_hi, ctrl_q.multiplier_select_lo})
         2'b00: op_div = 8'h08;
         2'b01: op_div = 8'h04;
         2'b10: op_div = 8'h02;
         2'b11: op_div = 8'h02;
      endcase
      arb_div  = ctrl_q.arb_clock_halving ? 8'h02 : 8'h01;
      rate_eff = ctrl_q.refinement_enable ? rsync2_q : ctrl_q.rate_prescale_select;
      rate_div = 8'h01 << rate_eff;
   end

   istr_rate_div #(.W(8)) u_op_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .en_i   (1'b1),
      .div_i  (op_div),
      .tick_o (op_tick)
   );

   istr_rate_div #(.W(8)) u_arb_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .en_i   (op_tick),
      .div_i  (arb_div),
      .tick_o (arb_tick_o)
   );

   istr_rate_div #(.W(8)) u_rate_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .en_i   (op_tick),
      .div_i  (rate_div),
      .tick_o (rate_tick_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave and registers
   always_comb begin
      req        = wb_cyc_i && wb_stb_i && !ack_q;
      cmd_wr     = req && wb_we_i && (wb_adr_i[4:2] == istr_pkg::OFF_CMD[4:2]);
      stall      = cmd_wr && (gap_q != 8'h00);
      ack_d      = req && !stall;
      wr_acc     = ack_d && wb_we_i && wb_sel_i[0];
      rd_acc     = ack_d && !wb_we_i;
      node_wr    = wr_acc && (wb_adr_i[4:2] == istr_pkg::OFF_NODE_ID[4:2]);
      clear_trig = !int_n_q && ((wr_acc && cmd_wr && ((wb_dat_i[7:0] == istr_pkg::CMD_CLR_TXRX_INT) ||
                   (wb_dat_i[7:0] == istr_pkg::CMD_CLR_FLAG))) ||
                   (rd_acc && (wb_adr_i[4:2] == istr_pkg::OFF_SUCC_ID[4:2])));
      ctrl_d = ctrl_q;
      node_d = node_q;
      mask_d = mask_q;
      ev_d   = ev_q | ev_set;
      dat_d  = 32'h0000_0000;
      if (wr_acc) begin
         unique case (wb_adr_i[4:2])
            istr_pkg::OFF_CTRL[4:2]:     ctrl_d = istr_pkg::istr_ctrl_s'(wb_dat_i[7:0]);
            istr_pkg::OFF_NODE_ID[4:2]:  node_d = wb_dat_i[7:0];
            istr_pkg::OFF_INT_MASK[4:2]: mask_d = wb_dat_i[7:0];
            istr_pkg::OFF_INT_STAT[4:2]: ev_d = (ev_q & ~wb_dat_i[istr_pkg::EV_W-1:0]) | ev_set;
            default: ;
         endcase
      end
      if (rd_acc) begin
         unique case (wb_adr_i[4:2])
            istr_pkg::OFF_CTRL[4:2]:     dat_d[7:0] = ctrl_q;
            istr_pkg::OFF_NODE_ID[4:2]:  dat_d[7:0] = node_q;
            istr_pkg::OFF_SUCC_ID[4:2]:  dat_d[7:0] = successor_identifier_i;
            istr_pkg::OFF_STATUS[4:2]: begin
               dat_d[istr_pkg::ST_TA]   = flag_q[0];
               dat_d[istr_pkg::ST_RI]   = flag_q[1];
               dat_d[istr_pkg::ST_BUSY] = istr_pkg::in_init_routine(upc_q);
               dat_d[istr_pkg::ST_RATE +: 3] = rate_eff;
            end
            istr_pkg::OFF_INT_STAT[4:2]: dat_d[istr_pkg::EV_W-1:0] = ev_q;
            istr_pkg::OFF_INT_MASK[4:2]: dat_d[7:0] = mask_q;
            default: ;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   ////////////////////////////////////////////////////////////////////////////
   // start-up ram initialization sequencer
   always_comb begin
      upc_d = upc_q;
      ram_d = '0;
      unique case (upc_q)
         istr_pkg::UPC_IDLE: begin
            if (node_wr) begin
               upc_d = istr_pkg::UPC_SYNC;
            end
         end
         istr_pkg::UPC_SYNC: begin
            // idle wait decoded away inside the init routine when bypassed
            if (idle_s2_q || (ctrl_q.idle_wait_bypass && istr_pkg::in_init_routine(upc_q))) begin
               upc_d = istr_pkg::UPC_WR_PAT;
            end
         end
         istr_pkg::UPC_WR_PAT: begin
            ram_d = '{we: 1'b1, addr: istr_pkg::INIT_ADDR0, data: istr_pkg::INIT_PATTERN};
            upc_d = istr_pkg::UPC_WR_ID;
         end
         istr_pkg::UPC_WR_ID: begin
            ram_d = '{we: 1'b1, addr: istr_pkg::INIT_ADDR1, data: node_q};
            upc_d = istr_pkg::UPC_IDLE;
         end
         default: upc_d = istr_pkg::UPC_IDLE;
      endcase
      ev_set = '0;
      ev_set[istr_pkg::EV_INIT] = (upc_q == istr_pkg::UPC_WR_ID);
      ev_set[istr_pkg::EV_TA]   = flag_d[0] && !flag_q[0];
      ev_set[istr_pkg::EV_RI]   = flag_d[1] && !flag_q[1];
   end

   assign ram_wr_o = ram_q;

   ////////////////////////////////////////////////////////////////////////////
   // timing refinements
   always_comb begin
      rsync1_d = rsync1_q;
      rsync2_d = rsync2_q;
      if (op_tick) begin
         rsync1_d = ctrl_q.rate_prescale_select;
         rsync2_d = rsync1_q;
      end
      // refined counts run on the system clock, legacy ones on rate ticks
      dis_d = dis_q;
      if (clear_trig) begin
         dis_d = ctrl_q.refinement_enable ? 8'(istr_pkg::INTDIS_REF_CYC) :
                 8'(istr_pkg::INTDIS_LEGACY_TICKS);
      end else if ((dis_q != 8'h00) && (ctrl_q.refinement_enable || rate_tick_o)) begin
         dis_d = dis_q - 8'h01;
      end
      gap_d = gap_q;
      if (cmd_wr && ack_d) begin
         gap_d = ctrl_q.refinement_enable ? 8'(istr_pkg::CMD_GAP_REF_CYC) :
                 8'(istr_pkg::CMD_GAP_LEGACY_TICKS);
      end else if ((gap_q != 8'h00) && (ctrl_q.refinement_enable || rate_tick_o)) begin
         gap_d = gap_q - 8'h01;
      end
      pulses = {ri_set_pulse_i, ta_set_pulse_i};
      for (int i = 0; i < 2; i++) begin
         flag_d[i] = flag_q[i];
         if (ctrl_q.refinement_enable ? (pulse_q[i] && !pulses[i]) : (pulses[i] && !pulse_q[i])) begin
            flag_d[i] = 1'b1;
         end else if (wr_acc && cmd_wr &&
                      (wb_dat_i[7:0] == (i == 0 ? istr_pkg::CMD_EN_TX : istr_pkg::CMD_EN_RX))) begin
            flag_d[i] = 1'b0;
         end
      end
      int_n_d = !((|(ev_q & mask_q[istr_pkg::EV_W-1:0])) && (dis_d == 8'h00));
   end

   assign transmitter_available_flag_o = flag_q[0];
   assign receiver_inhibited_flag_o    = flag_q[1];
   assign rate_prescale_select_o       = rate_eff;
   assign interrupt_out_n_o            = int_n_q;

   ////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q    <= istr_pkg::istr_ctrl_s'(istr_pkg::CTRL_RST);
         node_q    <= istr_pkg::NODE_RST;
         mask_q    <= istr_pkg::MASK_RST;
         ev_q      <= '0;
         ack_q     <= 1'b0;
         dat_q     <= 32'h0000_0000;
         idle_s1_q <= 1'b0;
         idle_s2_q <= 1'b0;
         upc_q     <= istr_pkg::UPC_IDLE;
         ram_q     <= '0;
         rsync1_q  <= 3'h0;
         rsync2_q  <= 3'h0;
         dis_q     <= 8'h00;
         gap_q     <= 8'h00;
         flag_q    <= 2'h0;
         pulse_q   <= 2'h0;
         int_n_q   <= 1'b1;
      end else begin
         ctrl_q    <= ctrl_d;
         node_q    <= node_d;
         mask_q    <= mask_d;
         ev_q      <= ev_d;
         ack_q     <= ack_d;
         dat_q     <= dat_d;
         idle_s1_q <= line_idle_i;
         idle_s2_q <= idle_s1_q;
         upc_q     <= upc_d;
         ram_q     <= ram_d;
         rsync1_q  <= rsync1_d;
         rsync2_q  <= rsync2_d;
         dis_q     <= dis_d;
         gap_q     <= gap_d;
         flag_q    <= flag_d;
         pulse_q   <= pulses;
         int_n_q   <= int_n_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_init_idle_wait: assert property (
      (upc_q == istr_pkg::UPC_SYNC) && !ctrl_q.idle_wait_bypass && !idle_s2_q
      |=> upc_q == istr_pkg::UPC_SYNC) else $error("init left idle wait on busy line");
   a_init_bypass_go: assert property (
      (upc_q == istr_pkg::UPC_SYNC) && ctrl_q.idle_wait_bypass
      |=> upc_q == istr_pkg::UPC_WR_PAT) else $error("bypassed init stalled");
   a_init_ram_pair: assert property (
      (upc_q == istr_pkg::UPC_WR_PAT)
      |=> ram_wr_o.we && (ram_wr_o.addr == 11'h000) && (ram_wr_o.data == 8'hd1)
      ##1 ram_wr_o.we && (ram_wr_o.addr == 11'h001) && (ram_wr_o.data == node_q))
      else $error("init ram writes wrong");
   a_init_in_time: assert property (
      node_wr && (upc_q == istr_pkg::UPC_IDLE) && ctrl_q.idle_wait_bypass
      |-> ##[1:INIT_BOUND] ram_wr_o.we && (ram_wr_o.addr == 11'h001))
      else $error("init not done within 6 us");
   a_int_clear_dis: assert property (clear_trig |=> interrupt_out_n_o) else $error("interrupt not deasserted");
   a_int_dis_long: assert property (
      clear_trig && ctrl_q.refinement_enable
      |=> interrupt_out_n_o [*8] ##1 interrupt_out_n_o [*3]) else $error("refined disable too short");
   a_cmd_gap_ref: assert property (
      cmd_wr && ack_d && ctrl_q.refinement_enable
      |=> !(cmd_wr && ack_d) [*5]) else $error("command spacing under 100 ns");
   a_cmd_gap_leg: assert property (
      cmd_wr && ack_d && !ctrl_q.refinement_enable
      |=> (gap_q == 8'h02)) else $error("legacy command spacing not armed");
   a_rate_sync: assert property (
      ctrl_q.refinement_enable && $changed(ctrl_q.rate_prescale_select)
      |-> $stable(rate_prescale_select_o)) else $error("rate select not synchronized");
   a_flag_late: assert property (
      ctrl_q.refinement_enable && $fell(ta_set_pulse_i)
      |=> transmitter_available_flag_o) else $error("refined flag missed pulse end");
   a_flag_early: assert property (
      !ctrl_q.refinement_enable && $rose(ta_set_pulse_i)
      |=> transmitter_available_flag_o) else $error("legacy flag missed pulse start");
   a_arb_half: assert property (
      (!arb_tick_o || op_tick) && (ctrl_q.arb_clock_halving || (arb_tick_o == op_tick)))
      else $error("arb tick wrong");

endmodule : istr_top

// file: bench/istr_host_model.sv
/*
 * host microcontroller model: classic wishbone master with one access task.
 * assumes one clock shared with the block and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module istr_host_model #(
   parameter int GAP = 1
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   output logic                             wb_cyc_o,
   output logic                             wb_stb_o,
   output logic                             wb_we_o,
   output logic [istr_pkg::WB_AW-1:0]       wb_adr_o,
   output logic [31:0]                      wb_dat_o,
   output logic [3:0]                       wb_sel_o,
   input  wire logic [31:0]                 wb_dat_i,
   input  wire logic                        wb_ack_i
);
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o  = 1'b0;
      wb_adr_o = 5'h00;
      wb_dat_o = 32'h0;
      wb_sel_o = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one classic cycle, released only at the edge that sees ack
   task automatic access(input logic we, input logic [4:0] adr, input logic [7:0] wd, output logic [7:0] rd);
      while (rst_i !== 1'b0) @(posedge clk_i);
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= we;
      wb_adr_o <= adr;
      wb_dat_o <= {24'h0, wd};
      wb_sel_o <= 4'h1;
      do @(posedge clk_i); while (wb_ack_i !== 1'b1);
      rd = wb_dat_i[7:0];
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_adr_o <= ~adr;
      wb_dat_o <= ~{24'h0, wd};
      wb_sel_o <= 4'h0;
      repeat (GAP) @(posedge clk_i);
   endtask : access
endmodule : istr_host_model

// file: bench/testbench.sv
/*
 * self-checking bench: init gating, interrupt disable, spacing, flags, clocks.
 * assumes the block top and the host model; 50 MHz clock.
 */
`timescale 1ns/10ps
module testbench;
   logic                        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, line_idle, ta_pulse, ri_pulse;
   logic [4:0]                  wb_adr;
   logic [31:0]                 wb_dat_w, wb_dat_r;
   logic [3:0]                  wb_sel;
   logic [7:0]                  succ_id, rd;
   logic                        ta_flag, ri_flag, arb_tick, rate_tick, int_n;
   logic [2:0]                  rate_sel;
   istr_pkg::istr_ram_wr_s      ram_wr;
   logic [18:0]                 ramq[$];
   int                          n_errors, comparisons, cyc_n, hi_len, hi_ticks, last_len, last_ticks, t1, t2;

   istr_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
      .wb_adr_o(wb_adr), .wb_dat_o(wb_dat_w), .wb_sel_o(wb_sel), .wb_dat_i(wb_dat_r), .wb_ack_i(wb_ack));
   istr_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
      .line_idle_i(line_idle), .successor_identifier_i(succ_id), .ta_set_pulse_i(ta_pulse),
      .ri_set_pulse_i(ri_pulse), .transmitter_available_flag_o(ta_flag), .receiver_inhibited_flag_o(ri_flag),
      .ram_wr_o(ram_wr), .arb_tick_o(arb_tick), .rate_tick_o(rate_tick), .rate_prescale_select_o(rate_sel),
      .interrupt_out_n_o(int_n));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // monitors: cycle count, ram writes, interrupt high runs, timeout
   initial begin
      cyc_n = 0; hi_len = 0; hi_ticks = 0; last_len = 0; last_ticks = 0;
   end
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (ram_wr.we === 1'b1) ramq.push_back({ram_wr.addr, ram_wr.data});
      if (int_n === 1'b1) begin
         hi_len   <= hi_len + 1;
         hi_ticks <= hi_ticks + int'(rate_tick);
      end else begin
         if (hi_len > 0) begin
            last_len   <= hi_len;
            last_ticks <= hi_ticks;
         end
         hi_len   <= 0;
         hi_ticks <= 0;
      end
      if (cyc_n == 40000) begin
         n_errors++;
         $display("mismatch at %0t: run timed out", $time);
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      i_host.access(1'b1, a, d, rd);
   endtask : wr
   task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string what);
      i_host.access(1'b0, a, 8'h00, rd);
      chk({24'h0, rd}, {24'h0, e}, what);
   endtask : rdc
   task automatic wait_ram;
      int k;
      k = 0;
      while (ramq.size() < 2 && k < istr_pkg::INIT_LIMIT_CYC) begin
         @(posedge clk_i);
         k++;
      end
   endtask : wait_ram
   task automatic wait_low;
      int k;
      k = 0;
      while (int_n !== 1'b0 && k < 400) begin
         @(posedge clk_i);
         k++;
      end
      @(posedge clk_i);
   endtask : wait_low
   task automatic next_arb(output int at);
      int k;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (arb_tick !== 1'b1 && k < 100);
      at = cyc_n;
   endtask : next_arb
   task automatic tally_and_finish;
      if (n_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_i = 1'b1; line_idle = 1'b0; ta_pulse = 1'b0; ri_pulse = 1'b0; succ_id = 8'ha5;
      n_errors = 0; comparisons = 0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({29'h0, int_n, ri_flag, ta_flag}, 32'h4, "outputs after reset");
      rdc(istr_pkg::OFF_CTRL, istr_pkg::CTRL_RST, "ctrl reset");
      rdc(istr_pkg::OFF_INT_MASK, istr_pkg::MASK_RST, "mask reset");
      rdc(istr_pkg::OFF_INT_STAT, 8'h00, "event reset");
      rdc(istr_pkg::OFF_CMD, 8'h00, "command reads zero");
      wr(5'h1c, 8'hff);
      rdc(5'h1c, 8'h00, "unmapped reads zero");
      // init held while line busy, then written once idle
      wr(istr_pkg::OFF_NODE_ID, 8'h5a);
      repeat (2 * istr_pkg::INIT_LIMIT_CYC) @(posedge clk_i);
      chk(ramq.size(), 0, "init held on busy line");
      rdc(istr_pkg::OFF_STATUS, 8'h04, "init busy");
      line_idle <= 1'b1;
      wait_ram();
      chk(ramq.size(), 2, "init after idle");
      chk({13'h0, ramq[0]}, {13'h0, istr_pkg::INIT_ADDR0, istr_pkg::INIT_PATTERN}, "pattern word");
      chk({13'h0, ramq[1]}, {13'h0, istr_pkg::INIT_ADDR1, 8'h5a}, "id word");
      ramq.delete();
      // bypass on a busy line
      line_idle <= 1'b0;
      wr(istr_pkg::OFF_CTRL, 8'h01);
      wr(istr_pkg::OFF_NODE_ID, 8'h33);
      wait_ram();
      chk(ramq.size(), 2, "bypass init within limit");
      chk({13'h0, ramq[1]}, {13'h0, istr_pkg::INIT_ADDR1, 8'h33}, "bypass id word");
      rdc(istr_pkg::OFF_INT_STAT, 8'h01, "init done event");
      // interrupt: masked, raised, disabled by three causes in both modes
      chk({31'h0, int_n}, 32'h1, "masked event stays quiet");
      wr(istr_pkg::OFF_INT_MASK, 8'h01);
      repeat (3) @(posedge clk_i);
      chk({31'h0, int_n}, 32'h0, "unmasked event raises");
      for (int m = 0; m < 2; m++) begin
         wr(istr_pkg::OFF_CTRL, (m == 0) ? 8'h03 : 8'h01);
         for (int k = 0; k < 3; k++) begin
            last_len = 0;
            last_ticks = 0;
            if (k == 2)
               rdc(istr_pkg::OFF_SUCC_ID, 8'ha5, "successor id");
            else
               wr(istr_pkg::OFF_CMD, (k == 0) ? istr_pkg::CMD_CLR_TXRX_INT : istr_pkg::CMD_CLR_FLAG);
            wait_low();
            if (m == 0)
               chk(last_len * 20 > 200, 1, "refined disable over 200 ns");
            else
               chk(last_ticks >= 3 && last_ticks <= 5, 1, "legacy disable in rate ticks");
         end
      end
      wr(istr_pkg::OFF_INT_STAT, 8'h01);
      repeat (3) @(posedge clk_i);
      chk({31'h0, int_n}, 32'h1, "cleared event drops interrupt");
      // command spacing at a slow rate; select kept low-rate only
      for (int m = 0; m < 2; m++) begin
         wr(istr_pkg::OFF_CTRL, (m == 0) ? 8'h63 : 8'h61);
         repeat (20) @(posedge clk_i);
         chk({29'h0, rate_sel}, 32'h3, "rate select");
         rdc(istr_pkg::OFF_STATUS, 8'h30, "status rate field");
         wr(istr_pkg::OFF_CMD, istr_pkg::CMD_EN_TX);
         t1 = cyc_n;
         wr(istr_pkg::OFF_CMD, istr_pkg::CMD_EN_RX);
         t2 = cyc_n;
         if (m == 0)
            chk((t2 - t1) * 20 >= 100 && (t2 - t1) < 20, 1, "refined spacing");
         else
            chk(t2 - t1 >= 64, 1, "legacy spacing");
      end
      // flags: refined rise at pulse end, legacy at pulse start
      for (int m = 0; m < 2; m++) begin
         wr(istr_pkg::OFF_CTRL, (m == 0) ? 8'h03 : 8'h01);
         ta_pulse <= 1'b1;
         ri_pulse <= 1'b1;
         repeat (3) @(posedge clk_i);
         chk({30'h0, ri_flag, ta_flag}, (m == 0) ? 32'h0 : 32'h3, "flags during pulse");
         ta_pulse <= 1'b0;
         ri_pulse <= 1'b0;
         repeat (3) @(posedge clk_i);
         chk({30'h0, ri_flag, ta_flag}, 32'h3, "flags after pulse");
         wr(istr_pkg::OFF_CMD, istr_pkg::CMD_EN_TX);
         wr(istr_pkg::OFF_CMD, istr_pkg::CMD_EN_RX);
         repeat (2) @(posedge clk_i);
         chk({30'h0, ri_flag, ta_flag}, 32'h0, "enable clears flags");
      end
      rdc(istr_pkg::OFF_INT_STAT, 8'h06, "flag events");
      wr(istr_pkg::OFF_INT_STAT, 8'h06);
      rdc(istr_pkg::OFF_INT_STAT, 8'h00, "flag events cleared");
      // arbitration period over multiplier and halving settings
      for (int mu = 0; mu < 3; mu++) begin
         for (int h = 0; h < 2; h++) begin
            wr(istr_pkg::OFF_CTRL, 8'(mu * 8 + h * 4 + 3));
            next_arb(t1);
            next_arb(t1);
            next_arb(t2);
            chk(t2 - t1, (8 >> mu) * (h + 1), "arbitration period");
         end
      end
      tally_and_finish();
   end
endmodule : testbench
